// [rtl/umsi_pkg.sv]
// Constants for the two-channel modem status input block.
// Assumes a plain register port with one-cycle strobes and read data one cycle later.
package umsi_pkg;
    // Register word offsets on the plain port.
    localparam logic [3:0] STATUS0_ADDR = 4'h0;
    localparam logic [3:0] STATUS1_ADDR = 4'h1;
    localparam logic [3:0] IER_ADDR = 4'h2;
    // Field positions of the modem line status register.
    localparam int BIT_CTS_CHG = 0;
    localparam int BIT_DSR_CHG = 1;
    localparam int BIT_DCD_CHG = 3;
    localparam int BIT_CTS = 4;
    localparam int BIT_DSR = 5;
    localparam int BIT_DCD = 7;
    // Interrupt enable: bit n enables modem status interrupts of channel n.
    localparam logic [1:0] IER_RESET = 2'h0;
    localparam logic [2:0] PIN_RESET = 3'h7;
    localparam logic [7:0] RDATA_RESET = 8'h00;
endpackage

// [rtl/umsi_top.sv]
// Modem status input logic of two serial channels with a small register port.
// Assumes modem pins are synchronous to core_clk_i; read data appears one cycle after a read.
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module umsi_top
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic [1:0] cts_b_i,
    input wire logic [1:0] dsr_b_i,
    input wire logic [1:0] dcd_b_i,
    output logic [1:0] irq_o
);
    typedef struct packed {
        logic [1:0] ier;
        logic [1:0][2:0] pin;
        logic [1:0][2:0] chg;
        logic [7:0] rdata;
        logic [1:0] irq;
    } umsi_state_t;

    // Reset release through two flip-flops.
    logic [1:0] rst_sync;
    logic rst_b;
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_sync <= 2'h0;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_b = rst_sync[1];

    // Registered state, its next value, the live pins and the status read decode.
    umsi_state_t st;
    umsi_state_t next_st;
    logic [1:0][2:0] now;
    logic [1:0] rd_status;

    // Pins packed as {dcd, dsr, cts}, still active low as the modem drives them.
    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            now[c] = {dcd_b_i[c], dsr_b_i[c], cts_b_i[c]};
        end
        rd_status[0] = rd_i && (addr_i == umsi_pkg::STATUS0_ADDR);
        rd_status[1] = rd_i && (addr_i == umsi_pkg::STATUS1_ADDR);
    end

    // Next state: change detect, read clear with set winning, and readback.
    always_comb
    begin
        next_st = st;
        next_st.rdata = 8'h00;
        if (wr_i && addr_i == umsi_pkg::IER_ADDR)
        begin
            next_st.ier = wdata_i[1:0];
        end
        for (int c = 0; c < 2; c++)
        begin
            next_st.pin[c] = now[c];
            if (rd_status[c])
            begin
                next_st.rdata[umsi_pkg::BIT_CTS_CHG] = st.chg[c][0];
                next_st.rdata[umsi_pkg::BIT_DSR_CHG] = st.chg[c][1];
                next_st.rdata[umsi_pkg::BIT_DCD_CHG] = st.chg[c][2];
                next_st.rdata[umsi_pkg::BIT_CTS] = ~now[c][0];
                next_st.rdata[umsi_pkg::BIT_DSR] = ~now[c][1];
                next_st.rdata[umsi_pkg::BIT_DCD] = ~now[c][2];
            end
            // A change in the read cycle survives the clear; it is reported next time.
            next_st.chg[c] = (rd_status[c] ? 3'h0 : st.chg[c]) | (now[c] ^ st.pin[c]);
            // Clear-to-send feeds only this flag, its level bit and the interrupt, never a transmitter.
            next_st.irq[c] = st.ier[c] && (next_st.chg[c] != 3'h0);
        end
        if (rd_i && addr_i == umsi_pkg::IER_ADDR)
        begin
            next_st.rdata = {6'h00, st.ier};
        end
    end

    // State register; pins reset to the inactive level so no false change follows reset.
    always_ff @(posedge core_clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st.ier <= umsi_pkg::IER_RESET;
            st.pin <= {umsi_pkg::PIN_RESET, umsi_pkg::PIN_RESET};
            st.chg <= 6'h00;
            st.rdata <= umsi_pkg::RDATA_RESET;
            st.irq <= 2'h0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Both outputs come straight from the state register.
    assign rdata_o = st.rdata;
    assign irq_o = st.irq;

    // A pin change with interrupts enabled reaches irq one edge later, read or not.
    a_cts_chg_irq: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (st.ier[0] && $changed(cts_b_i[0])) |=> irq_o[0])
        else $error("cts change did not raise irq");
    a_cts_irq_ch1: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (st.ier[1] && $changed(cts_b_i[1])) |=> irq_o[1])
        else $error("cts change did not raise irq on channel 1");
    a_dcd_chg_irq: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (st.ier[1] && $changed(dcd_b_i[1])) |=> irq_o[1])
        else $error("dcd change did not raise irq");
    a_dcd_irq_ch0: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (st.ier[0] && $changed(dcd_b_i[0])) |=> irq_o[0])
        else $error("dcd change did not raise irq on channel 0");
    a_dsr_irq_ch0: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (st.ier[0] && $changed(dsr_b_i[0])) |=> irq_o[0])
        else $error("dsr change did not raise irq on channel 0");
    a_dsr_irq_ch1: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (st.ier[1] && $changed(dsr_b_i[1])) |=> irq_o[1])
        else $error("dsr change did not raise irq on channel 1");

    // Level bits read back the inverse of each pin as it stood in the read cycle.
    a_cts_level_rd: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        rd_status[0] |=> rdata_o[umsi_pkg::BIT_CTS] == ~$past(cts_b_i[0]))
        else $error("cts level wrong");
    a_cts_level_ch1: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        rd_status[1] |=> rdata_o[umsi_pkg::BIT_CTS] == ~$past(cts_b_i[1]))
        else $error("cts level wrong on channel 1");
    a_dcd_level_rd: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        rd_status[1] |=> rdata_o[umsi_pkg::BIT_DCD] == ~$past(dcd_b_i[1]))
        else $error("dcd level wrong");
    a_dcd_level_ch0: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        rd_status[0] |=> rdata_o[umsi_pkg::BIT_DCD] == ~$past(dcd_b_i[0]))
        else $error("dcd level wrong on channel 0");
    a_dsr_level_rd: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        rd_status[0] |=> rdata_o[umsi_pkg::BIT_DSR] == ~$past(dsr_b_i[0]))
        else $error("dsr level wrong");
    a_dsr_level_ch1: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        rd_status[1] |=> rdata_o[umsi_pkg::BIT_DSR] == ~$past(dsr_b_i[1]))
        else $error("dsr level wrong on channel 1");

    // Any pin change sets its own flag at the next edge, even in a read cycle.
    a_cts_flag_set0: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        $changed(cts_b_i[0]) |=> st.chg[0][0])
        else $error("cts flag not set on channel 0");
    a_cts_flag_set1: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        $changed(cts_b_i[1]) |=> st.chg[1][0])
        else $error("cts flag not set on channel 1");
    a_dcd_flag_set0: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        $changed(dcd_b_i[0]) |=> st.chg[0][2])
        else $error("dcd flag not set on channel 0");
    a_dcd_flag_set1: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        $changed(dcd_b_i[1]) |=> st.chg[1][2])
        else $error("dcd flag not set on channel 1");
    a_dsr_flag_set0: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        $changed(dsr_b_i[0]) |=> st.chg[0][1])
        else $error("dsr flag not set on channel 0");
    a_dsr_flag_set1: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        $changed(dsr_b_i[1]) |=> st.chg[1][1])
        else $error("dsr flag not set on channel 1");

    // A flag stays up until software reads that channel.
    a_cts_flag_held0: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (st.chg[0][0] && !rd_status[0]) |=> st.chg[0][0])
        else $error("cts flag dropped on channel 0");
    a_cts_flag_held1: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (st.chg[1][0] && !rd_status[1]) |=> st.chg[1][0])
        else $error("cts flag dropped on channel 1");
    a_dcd_flag_held0: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (st.chg[0][2] && !rd_status[0]) |=> st.chg[0][2])
        else $error("dcd flag dropped on channel 0");
    a_dcd_flag_held1: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (st.chg[1][2] && !rd_status[1]) |=> st.chg[1][2])
        else $error("dcd flag dropped on channel 1");
    a_dsr_flag_held0: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (st.chg[0][1] && !rd_status[0]) |=> st.chg[0][1])
        else $error("dsr flag dropped on channel 0");
    a_dsr_flag_held1: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (st.chg[1][1] && !rd_status[1]) |=> st.chg[1][1])
        else $error("dsr flag dropped on channel 1");

    // Change, two quiet cycles, then a read: the spacing keeps the flag path apart from set.
    sequence s_cts_flip;
        $changed(cts_b_i[0]) ##1 (!rd_status[0])[*2];
    endsequence
    sequence s_cts_flip1;
        $changed(cts_b_i[1]) ##1 (!rd_status[1])[*2];
    endsequence
    sequence s_dcd_flip0;
        $changed(dcd_b_i[0]) ##1 (!rd_status[0])[*2];
    endsequence
    sequence s_dcd_flip1;
        $changed(dcd_b_i[1]) ##1 (!rd_status[1])[*2];
    endsequence
    sequence s_dsr_flip0;
        $changed(dsr_b_i[0]) ##1 (!rd_status[0])[*2];
    endsequence
    sequence s_dsr_flip1;
        $changed(dsr_b_i[1]) ##1 (!rd_status[1])[*2];
    endsequence
    a_cts_flag_rd: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        s_cts_flip ##1 rd_status[0]
        |=> rdata_o[umsi_pkg::BIT_CTS_CHG])
        else $error("cts change flag lost");
    a_cts_flag_ch1: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        s_cts_flip1 ##1 rd_status[1]
        |=> rdata_o[umsi_pkg::BIT_CTS_CHG])
        else $error("cts change flag lost on channel 1");
    a_dcd_flag_rd: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        s_dcd_flip0 ##1 rd_status[0]
        |=> rdata_o[umsi_pkg::BIT_DCD_CHG])
        else $error("dcd change flag lost");
    a_dcd_flag_ch1: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        s_dcd_flip1 ##1 rd_status[1]
        |=> rdata_o[umsi_pkg::BIT_DCD_CHG])
        else $error("dcd change flag lost on channel 1");
    a_dsr_flag_rd0: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        s_dsr_flip0 ##1 rd_status[0]
        |=> rdata_o[umsi_pkg::BIT_DSR_CHG])
        else $error("dsr change flag lost on channel 0");
    a_dsr_flag_rd1: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        s_dsr_flip1 ##1 rd_status[1]
        |=> rdata_o[umsi_pkg::BIT_DSR_CHG])
        else $error("dsr change flag lost on channel 1");

    // A read with quiet pins leaves no flag and lets the interrupt fall.
    a_read_clears: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (rd_status[1] && $stable(now[1])) |=> st.chg[1] == 3'h0)
        else $error("read did not clear flags");
    a_read_clears0: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (rd_status[0] && $stable(now[0])) |=> st.chg[0] == 3'h0)
        else $error("read did not clear flags on channel 0");
    a_irq_drop0: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (rd_status[0] && $stable(now[0])) |=> !irq_o[0])
        else $error("irq stayed after read on channel 0");
    a_irq_drop1: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (rd_status[1] && $stable(now[1])) |=> !irq_o[1])
        else $error("irq stayed after read on channel 1");

    // The interrupt needs a flag and its enable, and stays while both hold.
    a_irq_needs_chg0: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        irq_o[0] |-> st.chg[0] != 3'h0)
        else $error("irq without flag on channel 0");
    a_irq_needs_chg1: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        irq_o[1] |-> st.chg[1] != 3'h0)
        else $error("irq without flag on channel 1");
    a_irq_needs_en0: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        irq_o[0] |-> $past(st.ier[0]))
        else $error("irq without enable on channel 0");
    a_irq_needs_en1: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        irq_o[1] |-> $past(st.ier[1]))
        else $error("irq without enable on channel 1");
    a_irq_holds0: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (st.ier[0] && st.chg[0] != 3'h0 && !rd_status[0]) |=> irq_o[0])
        else $error("irq missing while flag set on channel 0");
    a_irq_holds1: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (st.ier[1] && st.chg[1] != 3'h0 && !rd_status[1]) |=> irq_o[1])
        else $error("irq missing while flag set on channel 1");

    // Flags and interrupt of one channel ignore the other channel's pins.
    a_chan_apart: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (st.chg[0] == 3'h0 && $stable(now[0])) |=> (st.chg[0] == 3'h0 && !irq_o[0]))
        else $error("channel cross talk");
    a_chan_apart1: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (st.chg[1] == 3'h0 && $stable(now[1])) |=> (st.chg[1] == 3'h0 && !irq_o[1]))
        else $error("channel cross talk on channel 1");

    // Register port: data only after a read, spare bits zero, enable kept and read back.
    a_rdata_idle: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        !rd_i
        |=> rdata_o == 8'h00)
        else $error("read data outside the read answer cycle");
    a_spare_bits: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (rd_status[0] || rd_status[1])
        |=> (rdata_o & 8'h44) == 8'h00)
        else $error("spare status bits not zero");
    a_ier_write: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (wr_i && addr_i == umsi_pkg::IER_ADDR)
        |=> st.ier == $past(wdata_i[1:0]))
        else $error("enable write lost");
    a_ier_readback: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (rd_i && addr_i == umsi_pkg::IER_ADDR)
        |=> rdata_o == {6'h00, $past(st.ier)})
        else $error("enable readback wrong");
    a_unmapped_zero: assert property (@(posedge core_clk_i) disable iff (!rst_b)
        (rd_i && addr_i > umsi_pkg::IER_ADDR)
        |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
endmodule
`default_nettype wire

// [sim/umsi_modem.sv]
// Modem model that drives the active-low status lines of both channels.
// Assumes the bench loads new levels with a one-cycle load strobe.
`timescale 1ns/1ns
`default_nettype none
module umsi_modem
(
    input wire logic clk_i,
    input wire logic load_i,
    input wire logic [5:0] lvl_i,
    output logic [1:0] cts_b_o,
    output logic [1:0] dsr_b_o,
    output logic [1:0] dcd_b_o
);
    // Lines idle high, meaning not ready and no carrier.
    logic [5:0] lines = 6'h3f;
    // Plain always, so the idle level may be given at the declaration.
    always @(posedge clk_i)
    begin
        if (load_i)
        begin
            lines <= lvl_i;
        end
    end
    assign {dcd_b_o, dsr_b_o, cts_b_o} = lines;
endmodule
`default_nettype wire

// [sim/test_umsi_top.sv]
// Self-checking bench of the modem status block with random line changes.
// Assumes the modem model is compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_umsi_top;
    logic clk = 0, rst_b = 0, wr = 0, rd = 0, pend = 0, ld = 0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wd = 8'h00, rdat;
    logic [5:0] lvl = 6'h3f, cur = 6'h3f, chg = 6'h00;
    logic [1:0] cts, dsr, dcd, irq, ier = 2'h0;
    logic [7:0] exq[$];
    logic [31:0] seed = 32'h00012fad;
    int err_count = 0, n_tests = 0;
    // Free-running 100 MHz clock.
    always #5 clk = ~clk;
    umsi_top u_umsi_top(.core_clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wd),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdat), .cts_b_i(cts), .dsr_b_i(dsr), .dcd_b_i(dcd),
        .irq_o(irq));
    umsi_modem u_umsi_modem(.clk_i(clk), .load_i(ld), .lvl_i(lvl), .cts_b_o(cts),
        .dsr_b_o(dsr), .dcd_b_o(dcd));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
        exq.push_back(e);
        @(posedge clk) {rd, addr} <= {1'b1, a};
        @(posedge clk) rd <= 1'b0;
    endtask
    // A read returns live inverted levels and the flags, then clears that channel's flags.
    task automatic rd_chan(input int ch);
        rd_reg(4'(ch), {~cur[4+ch], 1'b0, ~cur[2+ch], ~cur[ch], chg[4+ch], 1'b0, chg[2+ch],
            chg[ch]});
        chg = chg & ~(6'h15 << ch);
    endtask
    // New line levels; the interrupt is checked once they have settled.
    task automatic set_lines(input logic [5:0] v);
        @(posedge clk) {ld, lvl} <= {1'b1, v};
        @(posedge clk) ld <= 1'b0;
        chg = chg | (cur ^ v);
        cur = v;
        repeat (2) @(posedge clk);
        #1 chk({6'h0, irq}, {6'h0, ier & {|(chg & 6'h2a), |(chg & 6'h15)}});
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watcher: read data stand only in the cycle after the strobe.
    always @(posedge clk) pend <= rd;
    always @(negedge clk)
        if (pend) chk(rdat, exq.pop_front());
    // Main sequence: reset, an unmapped read, idle reads, then random line traffic.
    initial
    begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(4'h3, 8'h00);
        rd_chan(0);
        rd_chan(1);
        for (int i = 0; i < 48; i++)
        begin
            seed = xs(seed);
            if (i % 8 == 0)
            begin
                @(posedge clk) {wr, addr, wd} <= {1'b1, 4'h2, 6'h0, seed[9:8]};
                @(posedge clk) wr <= 1'b0;
                ier = seed[9:8];
                rd_reg(4'h2, {6'h00, ier});
            end
            set_lines(seed[5:0]);
            if (seed[6]) rd_chan(0);
            if (seed[7]) rd_chan(1);
        end
        repeat (3) @(posedge clk);
        print_verdict();
    end
    // Watchdog far beyond the few hundred cycles the run needs.
    initial
    begin
        #100000;
        err_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
